// [design/pss_latch_bank.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// latching status cells, high or low per bit
// ----------------------------------------------------------------------
module pss_latch_bank
  import pss_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] LOW_MASK = '0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [WIDTH-1:0] cond,
  input wire logic readClr,
  output logic [WIDTH-1:0] latched_r
);

  logic [WIDTH-1:0] latched_nxt;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      if (LOW_MASK[i])
      begin : g_low
        // holds 0 after a drop until read, a new drop wins over the read
        assign latched_nxt[i] = cond[i] & (latched_r[i] | readClr);
      end
      else
      begin : g_high
        // holds 1 after an event until read, a new event wins over the read
        assign latched_nxt[i] = cond[i] | (latched_r[i] & ~readClr);
      end
    end
  endgenerate

  // one register process for the whole bank, so each bit has a single writer
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      latched_r <= '0;
    else
      latched_r <= latched_nxt;
  end

endmodule // pss_latch_bank

// [design/pss_mgmt_regs.sv]
`timescale 1ns/100ps
module pss_mgmt_regs
  import pss_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic XOVER_DEFAULT = 1'b1,
  parameter logic RX_TRI_DEFAULT = 1'b0,
  parameter logic VENDOR_GATE_DEFAULT = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut_r,
  output logic mdioOe_r,
  input wire logic [2:0] anegProgress,
  input wire logic anegComplete,
  input wire logic txSignalLost,
  input wire logic pllLockError,
  input wire logic falseCarrier,
  input wire logic invalidSymbol,
  input wire logic haltSymbol,
  input wire logic prematureEnd,
  input wire logic noSignal,
  input wire logic jabberDetect,
  input wire logic remoteFault,
  input wire logic linkValid,
  input wire logic remoteJabber,
  input wire logic polarityReversed,
  input wire logic [1:0] busMode,
  output logic auto_crossover_enable_r,
  output logic receive_output_tristate_r,
  output logic vendor_register_gate_r,
  output logic test_mux_select_r,
  output logic jabberInhibit_r,
  output logic autoPolarityInhibit_r,
  output logic sqeTestInhibit_r,
  output logic linkLossInhibit_r,
  output logic squelchInhibit_r
);

  // ----------------------------------------------------------------------
  // pin synchronisers and clock edge
  // ----------------------------------------------------------------------
  logic mdcMeta_r, mdcSync_r, mdcPrev_r, mdioMeta_r, mdioSync_r;
  logic mdcRise;
  logic mdioBit;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge clk_sys)
  begin
    mdcMeta_r <= mdc;
    mdcSync_r <= mdcMeta_r;
    mdioMeta_r <= mdioIn;
    mdioSync_r <= mdioMeta_r;
  end

  // previous management clock level for edge finding
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mdcPrev_r <= 1'b0;
    else
      mdcPrev_r <= mdcSync_r;
  end

  assign mdcRise = mdcSync_r & ~mdcPrev_r;
  assign mdioBit = mdioSync_r;

  // true for the vendor-reserved address range
  function automatic logic isVendor(input logic [4:0] addr);
    isVendor = (addr >= VENDOR_FIRST) && (addr <= VENDOR_LAST);
  endfunction

  // ----------------------------------------------------------------------
  // frame receiver
  // ----------------------------------------------------------------------
  pss_state_t state_r;
  logic [5:0] bitCnt_r;
  logic [11:0] hdr_r;
  logic [11:0] hdrFull;
  logic hdrDone, respondNxt, respond_r, isRead_r;
  logic [4:0] regAddr_r;
  logic [15:0] wrShift_r;
  logic [15:0] wrData;
  logic wrCommit;

  // preamble, start, header, turnaround, data
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= PSS_PRE;
      bitCnt_r <= 6'h00;
    end
    else if (mdcRise)
    begin
      unique case (state_r)
        PSS_PRE:
          if (mdioBit)
            bitCnt_r <= (bitCnt_r == PREAMBLE_BITS) ? bitCnt_r : bitCnt_r + 6'h01;
          else
          begin
            if (bitCnt_r == PREAMBLE_BITS)
              state_r <= PSS_START;
            bitCnt_r <= 6'h00;
          end
        PSS_START:
          state_r <= mdioBit ? PSS_HDR : PSS_PRE;
        PSS_HDR:
          if (bitCnt_r == HDR_LAST)
          begin
            state_r <= PSS_TA;
            bitCnt_r <= 6'h00;
          end
          else
            bitCnt_r <= bitCnt_r + 6'h01;
        PSS_TA:
          if (bitCnt_r == TA_LAST)
          begin
            state_r <= PSS_DATA;
            bitCnt_r <= 6'h00;
          end
          else
            bitCnt_r <= bitCnt_r + 6'h01;
        PSS_DATA:
          if (bitCnt_r == DATA_LAST)
          begin
            state_r <= PSS_PRE;
            bitCnt_r <= 6'h00;
          end
          else
            bitCnt_r <= bitCnt_r + 6'h01;
        default:
          state_r <= PSS_PRE;
      endcase
    end
  end

  assign hdrFull = {hdr_r[10:0], mdioBit};
  assign hdrDone = mdcRise && (state_r == PSS_HDR) && (bitCnt_r == HDR_LAST);
  // answer only our address, a legal opcode, and no vendor address while the vendor gate bit is set
  assign respondNxt = (hdrFull[9:5] == PHY_ADDR)
                      && ((hdrFull[11:10] == OP_READ) || (hdrFull[11:10] == OP_WRITE))
                      && !(isVendor(hdrFull[4:0]) && vendor_register_gate_r);

  // header shift and frame decision
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      hdr_r <= 12'h000;
      respond_r <= 1'b0;
      isRead_r <= 1'b0;
      regAddr_r <= 5'h00;
    end
    else if (mdcRise && (state_r == PSS_HDR))
    begin
      hdr_r <= hdrFull;
      if (hdrDone)
      begin
        respond_r <= respondNxt;
        isRead_r <= (hdrFull[11:10] == OP_READ);
        regAddr_r <= hdrFull[4:0];
      end
    end
  end

  // write data shift
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wrShift_r <= 16'h0000;
    else if (mdcRise && (state_r == PSS_DATA))
      wrShift_r <= wrData;
  end

  assign wrData = {wrShift_r[14:0], mdioBit};
  assign wrCommit = mdcRise && (state_r == PSS_DATA) && (bitCnt_r == DATA_LAST)
                    && respond_r && !isRead_r && (regAddr_r == REG_TENBASE_OPERATIONS);

  // ----------------------------------------------------------------------
  // status latches and read data
  // ----------------------------------------------------------------------
  logic readGo, rdClr17, rdClr18;
  logic [8:0] statLatch;
  logic [1:0] opsLatch;
  logic [15:0] rdData;

  assign readGo = hdrDone && respondNxt && (hdrFull[11:10] == OP_READ);
  assign rdClr17 = readGo && (hdrFull[4:0] == REG_DETAILED_STATUS);
  assign rdClr18 = readGo && (hdrFull[4:0] == REG_TENBASE_OPERATIONS);

  pss_latch_bank #(.WIDTH(9), .LOW_MASK(9'h001)) u_stat_latch (
    .clk_sys(clk_sys),
    .srst(srst),
    .cond({txSignalLost, pllLockError, falseCarrier, invalidSymbol, haltSymbol,
           prematureEnd, jabberDetect, remoteFault, linkValid}),
    .readClr(rdClr17),
    .latched_r(statLatch)
  );

  pss_latch_bank #(.WIDTH(2), .LOW_MASK(2'h0)) u_ops_latch (
    .clk_sys(clk_sys),
    .srst(srst),
    .cond({remoteJabber, polarityReversed}),
    .readClr(rdClr18),
    .latched_r(opsLatch)
  );

  // register read mux, snapshot taken before the latches clear
  always_comb
  begin
    rdData = 16'h0000;
    if (hdrFull[4:0] == REG_DETAILED_STATUS)
    begin
      rdData[ST_PROGRESS_LSB+2 -: 3] = anegProgress;
      rdData[ST_SIG_LOST -: 4] = statLatch[8:5];
      rdData[ST_HALT] = statLatch[4];
      rdData[ST_PREMATURE] = statLatch[3];
      rdData[ST_ANEG_DONE] = anegComplete;
      rdData[ST_NO_SIGNAL] = noSignal;
      rdData[ST_JABBER] = statLatch[2];
      rdData[ST_REMOTE_FAULT] = statLatch[1];
      rdData[ST_LINK] = statLatch[0];
    end
    else if (hdrFull[4:0] == REG_TENBASE_OPERATIONS)
    begin
      rdData[OP_REMOTE_JABBER] = opsLatch[1];
      rdData[OP_POL_REVERSED] = opsLatch[0];
      rdData[OP_BUS_MODE_LSB+1 -: 2] = busMode;
      rdData[OP_XOVER] = auto_crossover_enable_r;
      rdData[OP_RX_TRI] = receive_output_tristate_r;
      rdData[OP_VENDOR_GATE] = vendor_register_gate_r;
      rdData[OP_TEST_MUX] = test_mux_select_r;
      rdData[OP_JABBER_INH] = jabberInhibit_r;
      rdData[OP_RSVD_ONE] = RSVD_ONE_VALUE;
      rdData[OP_AUTOPOL_INH] = autoPolarityInhibit_r;
      rdData[OP_SQE_INH] = sqeTestInhibit_r;
      rdData[OP_LINKLOSS_INH] = linkLossInhibit_r;
      rdData[OP_SQUELCH_INH] = squelchInhibit_r;
    end
  end

  // ----------------------------------------------------------------------
  // serial data driver
  // ----------------------------------------------------------------------
  logic [15:0] txShift_r;

  // zero in second turnaround bit, then msb first, released after last bit
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mdioOe_r <= 1'b0;
      mdioOut_r <= 1'b0;
      txShift_r <= 16'h0000;
    end
    else if (mdcRise)
    begin
      if (readGo)
        txShift_r <= rdData;
      else if ((state_r == PSS_TA) && (bitCnt_r == 6'h00) && respond_r && isRead_r)
      begin
        mdioOe_r <= 1'b1;
        mdioOut_r <= 1'b0;
      end
      else if (mdioOe_r && (state_r == PSS_DATA) && (bitCnt_r == DATA_LAST))
      begin
        mdioOe_r <= 1'b0;
        mdioOut_r <= 1'b0;
      end
      else if (mdioOe_r && ((state_r == PSS_TA) || (state_r == PSS_DATA)))
      begin
        mdioOut_r <= txShift_r[15];
        txShift_r <= {txShift_r[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // writable controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      auto_crossover_enable_r <= XOVER_DEFAULT;
      receive_output_tristate_r <= RX_TRI_DEFAULT;
      vendor_register_gate_r <= VENDOR_GATE_DEFAULT;
      test_mux_select_r <= RST_TEST_MUX;
      jabberInhibit_r <= RST_JABBER_INH;
      autoPolarityInhibit_r <= RST_AUTOPOL_INH;
      sqeTestInhibit_r <= RST_SQE_INH;
      linkLossInhibit_r <= RST_LINKLOSS_INH;
      squelchInhibit_r <= RST_SQUELCH_INH;
    end
    else if (wrCommit)
    begin
      auto_crossover_enable_r <= wrData[OP_XOVER];
      receive_output_tristate_r <= wrData[OP_RX_TRI];
      vendor_register_gate_r <= wrData[OP_VENDOR_GATE];
      test_mux_select_r <= wrData[OP_TEST_MUX];
      jabberInhibit_r <= wrData[OP_JABBER_INH];
      autoPolarityInhibit_r <= wrData[OP_AUTOPOL_INH];
      sqeTestInhibit_r <= wrData[OP_SQE_INH];
      linkLossInhibit_r <= wrData[OP_LINKLOSS_INH];
      squelchInhibit_r <= wrData[OP_SQUELCH_INH];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_read_go;
    readGo;
  endsequence

  sequence s_ops_write;
    wrCommit;
  endsequence

  a_ta_drive: assert property (s_read_go |-> ##[1:200] (mdioOe_r && !mdioOut_r))
    else $error("read not answered with turnaround zero");
  a_fault_hold: assert property (statLatch[8] && !rdClr17 |=> statLatch[8])
    else $error("signal lost bit dropped before read");
  a_link_low: assert property (!statLatch[0] && !rdClr17 |=> !statLatch[0])
    else $error("link bit recovered before read");
  a_link_drop: assert property (!linkValid |=> !statLatch[0])
    else $error("link drop not latched");
  a_jabber_set: assert property (remoteJabber |=> opsLatch[1] [*1] ##1 (opsLatch[1] || $past(rdClr18)))
    else $error("remote jabber not latched");
  a_code_snap: assert property (rdClr17 |-> rdData[13:11] == anegProgress
                                && rdData[ST_ANEG_DONE] == anegComplete)
    else $error("progress code not in read data");
  a_bus_mode: assert property (rdClr18 |-> rdData[13:12] == busMode)
    else $error("bus mode not in read data");
  a_vendor_block: assert property (hdrDone && vendor_register_gate_r && isVendor(hdrFull[4:0])
                                   |=> !respond_r ##1 !mdioOe_r)
    else $error("vendor access answered while gated");
  a_ctl_write: assert property (s_ops_write |=> receive_output_tristate_r == $past(wrData[OP_RX_TRI])
                                && sqeTestInhibit_r == $past(wrData[OP_SQE_INH]))
    else $error("control write not taken");
  a_ctl_stable: assert property (!wrCommit |=> $stable(squelchInhibit_r)
                                 && $stable(autoPolarityInhibit_r))
    else $error("control changed without write");

endmodule // pss_mgmt_regs

// [inc/pss_pkg.sv]
// ----------------------------------------------------------------------
// management register constants
// ----------------------------------------------------------------------
package pss_pkg;

  // register addresses on the management bus
  localparam logic [4:0] REG_DETAILED_STATUS = 5'h11;
  localparam logic [4:0] REG_TENBASE_OPERATIONS = 5'h12;
  localparam logic [4:0] VENDOR_FIRST = 5'h19;
  localparam logic [4:0] VENDOR_LAST = 5'h1F;

  // frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0B;
  localparam logic [5:0] TA_LAST = 6'h01;
  localparam logic [5:0] DATA_LAST = 6'h0F;

  // detailed status field positions
  localparam int ST_PROGRESS_LSB = 11;
  localparam int ST_SIG_LOST = 10;
  localparam int ST_PLL_ERR = 9;
  localparam int ST_FALSE_CARRIER = 8;
  localparam int ST_INVALID_SYM = 7;
  localparam int ST_HALT = 6;
  localparam int ST_PREMATURE = 5;
  localparam int ST_ANEG_DONE = 4;
  localparam int ST_NO_SIGNAL = 3;
  localparam int ST_JABBER = 2;
  localparam int ST_REMOTE_FAULT = 1;
  localparam int ST_LINK = 0;

  // operations field positions
  localparam int OP_REMOTE_JABBER = 15;
  localparam int OP_POL_REVERSED = 14;
  localparam int OP_BUS_MODE_LSB = 12;
  localparam int OP_XOVER = 11;
  localparam int OP_RX_TRI = 10;
  localparam int OP_VENDOR_GATE = 9;
  localparam int OP_TEST_MUX = 8;
  localparam int OP_JABBER_INH = 5;
  localparam int OP_RSVD_ONE = 4;
  localparam int OP_AUTOPOL_INH = 3;
  localparam int OP_SQE_INH = 2;
  localparam int OP_LINKLOSS_INH = 1;
  localparam int OP_SQUELCH_INH = 0;

  // reset values of the plain writable controls, then the fixed reserved bit value
  localparam logic RST_TEST_MUX = 1'b0;
  localparam logic RST_JABBER_INH = 1'b0;
  localparam logic RST_AUTOPOL_INH = 1'b0;
  localparam logic RST_SQE_INH = 1'b0;
  localparam logic RST_LINKLOSS_INH = 1'b0;
  localparam logic RST_SQUELCH_INH = 1'b0;
  localparam logic RSVD_ONE_VALUE = 1'b1;

  // frame receiver states, gray from preamble through to data (data back to preamble changes two bits)
  typedef enum logic [2:0] {
    PSS_PRE = 3'h0,
    PSS_START = 3'h1,
    PSS_HDR = 3'h3,
    PSS_TA = 3'h2,
    PSS_DATA = 3'h6
  } pss_state_t;

endpackage

// [tb/pss_sta_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// station manager model: frames on mdc and mdio
// ----------------------------------------------------------------------
module pss_sta_model
  import pss_pkg::*;
(
  input wire logic mdioWire,
  output logic mdc,
  output logic staOut,
  output logic staOe
);
  localparam int HALF = 80;

  // mdc stands still low and mdio is released between frames
  initial
  begin
    mdc = 1'b0;
    staOut = 1'b0;
    staOe = 1'b0;
  end

  // one whole frame; rdata holds the second turnaround bit above the data
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regA,
                       input logic [15:0] wdata, output logic [16:0] rdata);
    logic [63:0] bits;
    logic [15:0] w;
    w = wdata;
    if (regA == REG_TENBASE_OPERATIONS)
    begin
      w[7:6] = 2'b00;
      w[OP_RSVD_ONE] = RSVD_ONE_VALUE;
    end
    bits = {32'hFFFFFFFF, 2'b01, op, phy, regA, 2'b10, w};
    rdata = '1;
    for (int i = 63; i >= 0; i--)
    begin
      staOe = (op == OP_WRITE) || (i > 17); // release from turnaround on reads
      staOut = bits[i];
      #HALF;
      mdc = 1'b1;
      if (i == 16)
        rdata[16] = mdioWire;
      if (i < 16)
        rdata[i] = mdioWire;
      #HALF;
      mdc = 1'b0;
    end
    staOe = 1'b0;
  endtask
endmodule // pss_sta_model

// [tb/tb.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// testbench for the management register bank
// ----------------------------------------------------------------------
module tb
  import pss_pkg::*;
;
  localparam logic [4:0] PHY = 5'h01;
  typedef struct packed {
    logic [15:0] st;
    logic [3:0] hi;
    logic [15:0] w;
    logic [15:0] ex;
  } pss_tb_row_t;

  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] stat = 16'h0008;
  logic [3:0] hi = 4'h0;
  logic mdc, staOut, staOe, mdioOut, mdioOe;
  wire logic mdioWire;
  logic [8:0] ctlOut;
  logic [16:0] rd;
  int errors = 0;
  int n_tests = 0;
  pss_tb_row_t rows [4] = '{
    '{16'h0000, 4'h0, 16'h0000, 16'h0010},
    '{16'h3FFF, 4'hF, 16'hFFFF, 16'hFF3F},
    '{16'h2A55, 4'h6, 16'h0A25, 16'h6A35},
    '{16'h15AA, 4'h9, 16'h050A, 16'h951A}};

  // clock and mdio wire with pull-up
  always #2.5 clk_sys = ~clk_sys;
  assign mdioWire = mdioOe ? mdioOut : (staOe ? staOut : 1'b1);

  pss_mgmt_regs #(.PHY_ADDR(PHY)) uut (
    .clk_sys(clk_sys), .srst(srst), .mdc(mdc), .mdioIn(mdioWire),
    .mdioOut_r(mdioOut), .mdioOe_r(mdioOe),
    .anegProgress(stat[13:11]), .anegComplete(stat[4]), .txSignalLost(stat[10]),
    .pllLockError(stat[9]), .falseCarrier(stat[8]), .invalidSymbol(stat[7]),
    .haltSymbol(stat[6]), .prematureEnd(stat[5]), .noSignal(stat[3]),
    .jabberDetect(stat[2]), .remoteFault(stat[1]), .linkValid(stat[0]),
    .remoteJabber(hi[3]), .polarityReversed(hi[2]), .busMode(hi[1:0]),
    .auto_crossover_enable_r(ctlOut[8]), .receive_output_tristate_r(ctlOut[7]),
    .vendor_register_gate_r(ctlOut[6]), .test_mux_select_r(ctlOut[5]),
    .jabberInhibit_r(ctlOut[4]), .autoPolarityInhibit_r(ctlOut[3]),
    .sqeTestInhibit_r(ctlOut[2]), .linkLossInhibit_r(ctlOut[1]),
    .squelchInhibit_r(ctlOut[0]));

  pss_sta_model sta (.mdioWire(mdioWire), .mdc(mdc), .staOut(staOut), .staOe(staOe));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] a,
                      input logic [15:0] w, output logic [16:0] d);
    @(negedge clk_sys);
    sta.frame(op, phy, a, w, d);
  endtask

  // read and expect a driven turnaround zero plus the word
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [16:0] d;
    xfer(OP_READ, PHY, a, 16'h0000, d);
    chk(d, {1'b0, exp});
  endtask

  task automatic ctl(input logic [15:0] w);
    chk({8'h00, ctlOut}, {8'h00, w[11:8], w[5], w[3:0]});
  endtask

  // set conditions, or toggle some for one clock
  task automatic setc(input logic [15:0] s, input logic [3:0] h);
    @(negedge clk_sys);
    stat = s;
    hi = h;
  endtask

  task automatic pulse(input logic [15:0] s, input logic [3:0] h);
    setc(stat ^ s, hi ^ h);
    setc(stat ^ s, hi ^ h);
  endtask

  task automatic final_report;
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    rdc(REG_DETAILED_STATUS, 16'h0008);
    rdc(REG_TENBASE_OPERATIONS, 16'h0810);
    ctl(16'h0800);
    // table rows, latches flushed before each compare
    foreach (rows[k])
    begin
      setc(rows[k].st, rows[k].hi);
      xfer(OP_WRITE, PHY, REG_TENBASE_OPERATIONS, rows[k].w, rd);
      xfer(OP_READ, PHY, REG_DETAILED_STATUS, 16'h0000, rd);
      xfer(OP_READ, PHY, REG_TENBASE_OPERATIONS, 16'h0000, rd);
      rdc(REG_DETAILED_STATUS, rows[k].st);
      rdc(REG_TENBASE_OPERATIONS, rows[k].ex);
      ctl(rows[k].w);
    end
    // one-clock events stay latched until read
    setc(16'h0000, 4'h0);
    xfer(OP_READ, PHY, REG_DETAILED_STATUS, 16'h0000, rd);
    xfer(OP_READ, PHY, REG_TENBASE_OPERATIONS, 16'h0000, rd);
    pulse(16'h07E6, 4'hC);
    rdc(REG_DETAILED_STATUS, 16'h07E6);
    rdc(REG_DETAILED_STATUS, 16'h0000);
    rdc(REG_TENBASE_OPERATIONS, 16'hC51A);
    rdc(REG_TENBASE_OPERATIONS, 16'h051A);
    // short link drop stays low until read
    setc(16'h0001, 4'h0);
    xfer(OP_READ, PHY, REG_DETAILED_STATUS, 16'h0000, rd);
    pulse(16'h0001, 4'h0);
    rdc(REG_DETAILED_STATUS, 16'h0000);
    rdc(REG_DETAILED_STATUS, 16'h0001);
    // refused and read-only accesses
    xfer(OP_WRITE, PHY, REG_DETAILED_STATUS, 16'hFFFF, rd);
    rdc(REG_DETAILED_STATUS, 16'h0001);
    xfer(OP_WRITE, PHY ^ 5'h01, REG_TENBASE_OPERATIONS, 16'h0F2F, rd);
    rdc(REG_TENBASE_OPERATIONS, 16'h051A);
    xfer(OP_READ, PHY ^ 5'h01, REG_TENBASE_OPERATIONS, 16'h0000, rd);
    chk(rd, 17'h1FFFF);
    rdc(VENDOR_FIRST, 16'h0000);
    xfer(OP_WRITE, PHY, REG_TENBASE_OPERATIONS, 16'h0200, rd);
    ctl(16'h0200);
    xfer(OP_READ, PHY, VENDOR_LAST, 16'h0000, rd);
    chk(rd, 17'h1FFFF);
    rdc(REG_TENBASE_OPERATIONS, 16'h0210);
    // mid-run reset restores control defaults and clears the latches
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    ctl(16'h0800);
    rdc(REG_DETAILED_STATUS, 16'h0000);
    rdc(REG_TENBASE_OPERATIONS, 16'h0810);
    final_report();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    final_report();
  end
endmodule // tb
